// ### rb_auto_cell.sv
`timescale 1ns/1ps
// Bits that leave their rest value when kicked and return to it on their own.
module rb_auto_cell import rb_pkg::*; #(
    parameter int W = 16,
    parameter logic REST = 1'b0,
    parameter int HOLD = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic soft_reset,
    input wire logic [W-1:0] kick,
    output logic [W-1:0] value
);

    // Counter wide enough to hold the full hold time.
    localparam int CW = $clog2(HOLD + 1);
    localparam logic [CW-1:0] HOLD_C = CW'(HOLD);

    // Refuse settings the counter cannot serve, at elaboration rather than at run time.
    if (HOLD < 1 || W < 1) begin : g_bad_param
        $error("rb_auto_cell needs a hold time and width of at least one");
    end

    for (genvar i = 0; i < W; i++) begin : g_bit
        logic [CW-1:0] cnt_reg;
        logic [CW-1:0] cnt_next;
        logic val_reg;
        logic val_next;

        // A kick while already away from rest is ignored, so a rewrite cannot stretch it.
        always_comb begin
            cnt_next = cnt_reg;
            if (cnt_reg != '0) begin
                cnt_next = cnt_reg - CW'(1);
            end else if (kick[i]) begin
                cnt_next = HOLD_C;
            end
            if (soft_reset) begin
                cnt_next = '0;
            end
            val_next = REST ^ (cnt_next != '0);
        end

        // Value is registered so the hardware side sees a clean level.
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                cnt_reg <= '0;
                val_reg <= REST;
            end else if (ce) begin
                cnt_reg <= cnt_next;
                val_reg <= val_next;
            end
        end

        assign value[i] = val_reg;
    end

endmodule // rb_auto_cell

// ### rb_bank.sv
`timescale 1ns/1ps
// Contract
// - Readable bits read back; writable bits store writes.
// - Read-only bits ignore every write.
// - Write-only bits read back undefined data.
// - Writing one clears; writing zero does nothing.
// - Any write clears the whole field.
// - Read returns value, then clears; writes ignored.
// - Latched low holds until register read.
// - Latched high holds until register read.
// - Self-clearing bit returns to zero itself.
// - Self-setting bit returns to one itself.
// - Sticky status high until read, then live.
// - Sticky status holds one despite condition loss.
// - Exempt bits ignore software reset, obey hardware.
module rb_bank import rb_pkg::*; #(
    parameter int HOLD = RB_HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic soft_reset,
    input wire rb_req_t req,
    input wire rb_cond_t cond,
    output rb_rsp_t rsp,
    output logic [RB_DW-1:0] ctrl_out,
    output logic [RB_DW-1:0] wronly_out,
    output logic [RB_DW-1:0] selfclr_out,
    output logic [RB_DW-1:0] ss_out
);

    // Refuse a hold time the self-timed bits cannot serve, at elaboration.
    if (HOLD < 1) begin : g_bad_hold
        $error("rb_bank needs a hold time of at least one cycle");
    end

    // Decoded writes and reads, one per register except the status register.
    logic wr_ctrl;
    logic wr_wronly;
    logic wr_w1c;
    logic wr_anyclr;
    logic wr_selfclr;
    logic wr_ss;
    logic rd_rdclr;
    logic rd_latlo;
    logic rd_lathi;
    logic rd_stk;

    // Stored state of the sticky registers.
    logic [RB_DW-1:0] w1c_q;
    logic [RB_DW-1:0] anyclr_q;
    logic [RB_DW-1:0] rdclr_q;
    logic [RB_DW-1:0] latlo_q;
    logic [RB_DW-1:0] lathi_q;
    logic [RB_DW-1:0] stk_q;

    // Registered read answer.
    rb_rsp_t rsp_reg;
    rb_rsp_t rsp_next;

    // Writes to the read-only status registers are not decoded at all, so they cannot disturb them.
    always_comb begin
        wr_ctrl = req.wr && rb_hit(req, RB_OFF_CTRL);
        wr_wronly = req.wr && rb_hit(req, RB_OFF_WRONLY);
        wr_w1c = req.wr && rb_hit(req, RB_OFF_W1C);
        wr_anyclr = req.wr && rb_hit(req, RB_OFF_ANYCLR);
        wr_selfclr = req.wr && rb_hit(req, RB_OFF_SELFCLR);
        wr_ss = req.wr && rb_hit(req, RB_OFF_SS);
        rd_rdclr = req.rd && rb_hit(req, RB_OFF_RDCLR);
        rd_latlo = req.rd && rb_hit(req, RB_OFF_LATLO);
        rd_lathi = req.rd && rb_hit(req, RB_OFF_LATHI);
        rd_stk = req.rd && rb_hit(req, RB_OFF_STK);
    end

    // Plain read and write control word; its upper byte survives software reset.
    rb_latch_cell #(.W(RB_DW), .RST_VAL(RB_CTRL_RST), .EXEMPT(RB_CTRL_EXEMPT)) u_ctrl (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .set_in(wr_ctrl ? req.wdata : RB_ZERO),
        .clr_in(wr_ctrl ? ~req.wdata : RB_ZERO),
        .q(ctrl_out)
    );

    // Write-only word, driven to the hardware but never read back.
    rb_latch_cell #(.W(RB_DW)) u_wronly (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .set_in(wr_wronly ? req.wdata : RB_ZERO),
        .clr_in(wr_wronly ? ~req.wdata : RB_ZERO),
        .q(wronly_out)
    );

    // Cleared by ones in the write data, bit by bit.
    rb_latch_cell #(.W(RB_DW)) u_w1c (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .set_in(cond.w1c_set),
        .clr_in(wr_w1c ? req.wdata : RB_ZERO),
        .q(w1c_q)
    );

    // Cleared whole by any write, the data being ignored.
    rb_latch_cell #(.W(RB_DW)) u_anyclr (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .set_in(cond.anyclr_set),
        .clr_in(wr_anyclr ? RB_ONES : RB_ZERO),
        .q(anyclr_q)
    );

    // Cleared by a read, deaf to writes.
    rb_latch_cell #(.W(RB_DW)) u_rdclr (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .set_in(cond.rdclr_set),
        .clr_in(rd_rdclr ? RB_ONES : RB_ZERO),
        .q(rdclr_q)
    );

    // Remembers that a condition went low; the read value is the inverse ANDed with the live condition.
    rb_latch_cell #(.W(RB_DW)) u_latlo (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .set_in(~cond.latlo_cond),
        .clr_in(rd_latlo ? RB_ONES : RB_ZERO),
        .q(latlo_q)
    );

    // Remembers that a condition went high.
    rb_latch_cell #(.W(RB_DW)) u_lathi (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .set_in(cond.lathi_cond),
        .clr_in(rd_lathi ? RB_ONES : RB_ZERO),
        .q(lathi_q)
    );

    // Sticky status; the live condition is ORed in on the read side.
    rb_latch_cell #(.W(RB_DW)) u_stk (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .set_in(cond.stk_cond),
        .clr_in(rd_stk ? RB_ONES : RB_ZERO),
        .q(stk_q)
    );

    // Only ones in the write data start a self-clearing pulse.
    rb_auto_cell #(.W(RB_DW), .REST(1'b0), .HOLD(HOLD)) u_selfclr (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .kick(wr_selfclr ? req.wdata : RB_ZERO),
        .value(selfclr_out)
    );

    // Only zeros in the write data start a self-setting dip.
    rb_auto_cell #(.W(RB_DW), .REST(1'b1), .HOLD(HOLD)) u_ss (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .kick(wr_ss ? ~req.wdata : RB_ZERO),
        .value(ss_out)
    );

    // Read mux samples state before the clear-on-read edge takes effect.
    always_comb begin
        rsp_next.valid = req.rd;
        case (req.addr)
            RB_OFF_CTRL: rsp_next.data = ctrl_out;
            RB_OFF_STAT: rsp_next.data = cond.status;
            RB_OFF_WRONLY: rsp_next.data = RB_ZERO;
            RB_OFF_W1C: rsp_next.data = w1c_q;
            RB_OFF_ANYCLR: rsp_next.data = anyclr_q;
            RB_OFF_RDCLR: rsp_next.data = rdclr_q;
            RB_OFF_LATLO: rsp_next.data = ~latlo_q & cond.latlo_cond;
            RB_OFF_LATHI: rsp_next.data = lathi_q;
            RB_OFF_SELFCLR: rsp_next.data = selfclr_out;
            RB_OFF_SS: rsp_next.data = ss_out;
            RB_OFF_STK: rsp_next.data = stk_q | cond.stk_cond;
            default: rsp_next.data = RB_ZERO;
        endcase
        // Data only changes on a read, which keeps the bus quiet otherwise.
        if (!req.rd) begin
            rsp_next.data = rsp_reg.data;
        end
    end

    // Answer register.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rsp_reg <= '0;
        end else if (ce) begin
            rsp_reg <= rsp_next;
        end
    end

    assign rsp = rsp_reg;

    // Checks on the cells, all in the single clock domain.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // A control write is read back unchanged.
    property p_ctrl_store;
        ce && wr_ctrl && !soft_reset |=> ctrl_out == $past(req.wdata);
    endproperty
    a_ctrl_store: assert property (p_ctrl_store) else $error("control write not stored");

    // A write to the sticky status cannot clear it.
    property p_rdonly_ignore;
        ce && req.wr && !req.rd && !soft_reset && stk_q[0] |=> stk_q[0];
    endproperty
    a_rdonly_ignore: assert property (p_rdonly_ignore)
        else $error("read-only bit changed by write");

    // Ones clear, zeros keep, unless hardware sets.
    property p_w1c;
        ce && wr_w1c && !soft_reset |=>
            w1c_q == (($past(w1c_q) & ~$past(req.wdata)) | $past(cond.w1c_set));
    endproperty
    a_w1c: assert property (p_w1c) else $error("write-one-clear misbehaved");

    // Any write leaves only the bits set in the same cycle.
    property p_anyclr;
        ce && wr_anyclr && !soft_reset |=> anyclr_q == $past(cond.anyclr_set);
    endproperty
    a_anyclr: assert property (p_anyclr) else $error("write-any-clear misbehaved");

    // A read answers with the old value and then clears.
    property p_rdclr;
        ce && rd_rdclr && !soft_reset |=>
            rsp.valid && rsp.data == $past(rdclr_q) && rdclr_q == $past(cond.rdclr_set);
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("read-to-clear misbehaved");

    // A low condition is latched on the next edge while no read occurs.
    property p_latlo_hold;
        ce && !cond.latlo_cond[0] && !rd_latlo && !soft_reset |=> latlo_q[0];
    endproperty
    a_latlo_hold: assert property (p_latlo_hold) else $error("latch-low lost");

    // A high condition stays latched while no read occurs.
    property p_lathi_hold;
        ce && lathi_q[0] && !rd_lathi && !soft_reset |=> lathi_q[0];
    endproperty
    a_lathi_hold: assert property (p_lathi_hold) else $error("latch-high lost");

    // Self-clearing pulse: kicked from rest, high for four cycles, then low.
    sequence s_selfclr_kick;
        ce && wr_selfclr && req.wdata[0] && !selfclr_out[0] && !soft_reset;
    endsequence
    sequence s_selfclr_run;
        ##1 (ce && !soft_reset && selfclr_out[0]) [*4];
    endsequence
    property p_selfclr_pulse;
        s_selfclr_kick ##0 s_selfclr_run |=> !selfclr_out[0];
    endproperty
    a_selfclr_pulse: assert property (p_selfclr_pulse)
        else $error("self-clear timing wrong");

    // Self-setting bit falls after a zero write and is back within 20 cycles.
    property p_ss_dip;
        ce && wr_ss && !req.wdata[0] && ss_out[0] && !soft_reset |=> !ss_out[0] ##[1:20] ss_out[0];
    endproperty
    a_ss_dip: assert property (p_ss_dip) else $error("self-set did not recover");

    // Sticky status reads one after the condition even if it has gone.
    property p_stk_read;
        ce && rd_stk && stk_q[0] |=> rsp.data[0];
    endproperty
    a_stk_read: assert property (p_stk_read) else $error("sticky status read low");

    // Exempt control bits survive a software reset; the rest return to reset.
    property p_exempt;
        ce && soft_reset && !wr_ctrl |=>
            ctrl_out == (($past(ctrl_out) & RB_CTRL_EXEMPT) | (RB_CTRL_RST & ~RB_CTRL_EXEMPT));
    endproperty
    a_exempt: assert property (p_exempt)
        else $error("software reset touched exempt bits");

    // A set in the same cycle as a clear leaves the bit set.
    property p_set_wins;
        ce && rd_stk && cond.stk_cond[0] && !soft_reset |=> stk_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to a clear");

endmodule // rb_bank

// ### rb_bank_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the register bit cell bank, driven on the falling edge.
module rb_bank_tb import rb_pkg::*; ;

    logic clk; // Bench clock, 5 ns period.
    logic reset_n; // Hardware reset, active low.
    logic ce; // Clock enable for the whole bank.
    logic soft_reset; // Software reset strobe.
    rb_req_t req; // Register access from the bench.
    rb_cond_t cond; // Hardware conditions seen by the status cells.
    rb_cond_t idle_cond; // Quiet condition word, latch-low inputs held high.
    rb_rsp_t rsp; // Read answer.
    logic [RB_DW-1:0] ctrl_out; // Control word.
    logic [RB_DW-1:0] wronly_out; // Write-only word.
    logic [RB_DW-1:0] selfclr_out; // Self-clearing bits.
    logic [RB_DW-1:0] ss_out; // Self-setting bits.
    int n_fail = 0; // Mismatches seen.
    int cmp_count = 0; // Comparisons made.
    int seed = 32'h4fdf; // Fixed seed so every run repeats.
    logic [RB_DW-1:0] p; // Random pattern one.
    logic [RB_DW-1:0] q; // Random pattern two.

    rb_bank #(.HOLD(RB_HOLD_CYCLES)) u_rb_bank (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .req(req),
        .cond(cond),
        .rsp(rsp),
        .ctrl_out(ctrl_out),
        .wronly_out(wronly_out),
        .selfclr_out(selfclr_out),
        .ss_out(ss_out)
    );

    // Free running clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string name, input logic [RB_DW-1:0] seen,
                       input logic [RB_DW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One write; the extra leading edge keeps strobes from being reassigned in one step.
    task automatic wr(input logic [RB_AW-1:0] a, input logic [RB_DW-1:0] d);
        @(negedge clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
    endtask

    // One read; the answer stands one cycle, so it is sampled right after the taking edge.
    task automatic rchk(input logic [RB_AW-1:0] a, input logic [RB_DW-1:0] exp,
                        input string name);
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd = 1'b0;
        chk("read valid", {15'h0000, rsp.valid}, 16'h0001);
        chk(name, rsp.data, exp);
    endtask

    // Raises one condition field, or drops the latch-low bits, for a single cycle, then returns to quiet.
    task automatic pulse(input int f, input logic [RB_DW-1:0] m);
        @(negedge clk);
        case (f)
            0: cond.w1c_set = m;
            1: cond.anyclr_set = m;
            2: cond.rdclr_set = m;
            3: cond.lathi_cond = m;
            4: cond.stk_cond = m;
            default: cond.latlo_cond = ~m;
        endcase
        @(negedge clk);
        cond = idle_cond;
    endtask

    // Watchdog: a hang counts as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    // Main sequence.
    initial begin
        req = '0;
        ce = 1'b1;
        soft_reset = 1'b0;
        reset_n = 1'b0;
        idle_cond = '0;
        idle_cond.latlo_cond = RB_ONES;
        cond = idle_cond;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        chk("ctrl reset", ctrl_out, RB_CTRL_RST);
        chk("ss reset", ss_out, RB_ONES);
        chk("selfclr reset", selfclr_out, RB_ZERO);
        wr(4'hF, RB_ONES);
        rchk(4'hF, RB_ZERO, "unmapped");
        // Spare space is also written with zeros, as software is told to.
        wr(4'hF, RB_ZERO);
        rchk(RB_OFF_CTRL, RB_CTRL_RST, "spare write");
        for (int i = 0; i < 8; i++) begin
            p = RB_DW'($random(seed));
            q = RB_DW'($random(seed));
            // Corner patterns first: all ones, then a single bit.
            if (i == 0) begin
                p = RB_ONES;
            end
            if (i == 1) begin
                p = 16'h0001;
            end
            wr(RB_OFF_CTRL, p);
            chk("ctrl out", ctrl_out, p);
            rchk(RB_OFF_CTRL, p, "ctrl read");
            // The write-only read value is undefined, so only the output is checked.
            wr(RB_OFF_WRONLY, q);
            chk("wronly out", wronly_out, q);
            idle_cond.status = q;
            cond = idle_cond;
            wr(RB_OFF_STAT, ~q);
            rchk(RB_OFF_STAT, q, "status");
            // The race check below leaves bits set, so start this round from zero.
            wr(RB_OFF_W1C, RB_ONES);
            pulse(0, p);
            wr(RB_OFF_W1C, q);
            rchk(RB_OFF_W1C, p & ~q, "w1c");
            wr(RB_OFF_W1C, RB_ONES);
            // Set and clear meet in one cycle: the set must survive.
            cond.w1c_set = q;
            wr(RB_OFF_W1C, RB_ONES);
            cond = idle_cond;
            rchk(RB_OFF_W1C, q, "w1c race");
            pulse(1, p);
            wr(RB_OFF_ANYCLR, RB_ZERO);
            rchk(RB_OFF_ANYCLR, RB_ZERO, "anyclr");
            pulse(2, p);
            wr(RB_OFF_RDCLR, RB_ONES);
            rchk(RB_OFF_RDCLR, p, "rdclr value");
            rchk(RB_OFF_RDCLR, RB_ZERO, "rdclr cleared");
            pulse(5, p);
            wr(RB_OFF_LATLO, RB_ZERO);
            rchk(RB_OFF_LATLO, ~p, "latlo held");
            rchk(RB_OFF_LATLO, RB_ONES, "latlo cleared");
            pulse(3, p);
            wr(RB_OFF_LATHI, RB_ONES);
            rchk(RB_OFF_LATHI, p, "lathi held");
            rchk(RB_OFF_LATHI, RB_ZERO, "lathi cleared");
            // Condition gone before the read: the status must still show it.
            pulse(4, p);
            repeat (3) @(negedge clk);
            rchk(RB_OFF_STK, p, "stk held");
            rchk(RB_OFF_STK, RB_ZERO, "stk cleared");
            cond.stk_cond = q;
            rchk(RB_OFF_STK, q, "stk live");
            rchk(RB_OFF_STK, q, "stk persists");
            cond = idle_cond;
            rchk(RB_OFF_STK, q, "stk read race");
            rchk(RB_OFF_STK, RB_ZERO, "stk gone");
            // Self-clearing bits stand for the hold count, then drop.
            wr(RB_OFF_SELFCLR, p);
            for (int k = 0; k < RB_HOLD_CYCLES; k++) begin
                chk("selfclr run", selfclr_out, p);
                @(negedge clk);
            end
            chk("selfclr done", selfclr_out, RB_ZERO);
            wr(RB_OFF_SELFCLR, RB_ZERO);
            chk("selfclr zero write", selfclr_out, RB_ZERO);
            wr(RB_OFF_SS, q);
            for (int k = 0; k < RB_HOLD_CYCLES; k++) begin
                chk("ss run", ss_out, q);
                @(negedge clk);
            end
            chk("ss done", ss_out, RB_ONES);
            wr(RB_OFF_SS, RB_ONES);
            chk("ss one write", ss_out, RB_ONES);
        end
        // Software reset keeps only the exempt control bits.
        wr(RB_OFF_CTRL, p);
        pulse(0, q);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        chk("soft ctrl", ctrl_out, p & RB_CTRL_EXEMPT);
        rchk(RB_OFF_W1C, RB_ZERO, "soft w1c");
        // With the clock enable low a write must not be taken.
        ce = 1'b0;
        wr(RB_OFF_CTRL, ~p);
        ce = 1'b1;
        chk("frozen ctrl", ctrl_out, p & RB_CTRL_EXEMPT);
        // Hardware reset clears the exempt bits too.
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        chk("hard ctrl", ctrl_out, RB_CTRL_RST);
        complete_run();
    end

endmodule // rb_bank_tb

// ### rb_latch_cell.sv
`timescale 1ns/1ps
// Generic sticky storage: set events and clear requests, with set taking priority.
module rb_latch_cell import rb_pkg::*; #(
    parameter int W = 16,
    parameter logic [W-1:0] RST_VAL = '0,
    parameter logic [W-1:0] EXEMPT = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic soft_reset,
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] q
);

    // Stored bits and their next value.
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // Refuse a width the cell cannot hold, at elaboration rather than at run time.
    if (W < 1) begin : g_bad_width
        $error("rb_latch_cell needs a width of at least one bit");
    end

    // A set arriving with a clear wins so that no event is lost.
    always_comb begin
        q_next = (q_reg & ~clr_in) | set_in;
        // Exempt bits keep their value through a software reset.
        if (soft_reset) begin
            q_next = (q_next & EXEMPT) | (RST_VAL & ~EXEMPT);
        end
    end

    // Only the hardware reset reaches every bit.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q_reg <= RST_VAL;
        end else if (ce) begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule // rb_latch_cell

// ### rb_pkg.sv
// Shared constants, carriers and decode helpers for the register bit cell bank.
package rb_pkg;

    // Data and address widths of the register port.
    localparam int RB_DW = 16;
    localparam int RB_AW = 4;

    // Register offsets, one access behaviour per register.
    localparam logic [RB_AW-1:0] RB_OFF_CTRL = 4'h0;
    localparam logic [RB_AW-1:0] RB_OFF_STAT = 4'h1;
    localparam logic [RB_AW-1:0] RB_OFF_WRONLY = 4'h2;
    localparam logic [RB_AW-1:0] RB_OFF_W1C = 4'h3;
    localparam logic [RB_AW-1:0] RB_OFF_ANYCLR = 4'h4;
    localparam logic [RB_AW-1:0] RB_OFF_RDCLR = 4'h5;
    localparam logic [RB_AW-1:0] RB_OFF_LATLO = 4'h6;
    localparam logic [RB_AW-1:0] RB_OFF_LATHI = 4'h7;
    localparam logic [RB_AW-1:0] RB_OFF_SELFCLR = 4'h8;
    localparam logic [RB_AW-1:0] RB_OFF_SS = 4'h9;
    localparam logic [RB_AW-1:0] RB_OFF_STK = 4'hA;

    // Reset values and the mask of control bits that survive a software reset.
    localparam logic [RB_DW-1:0] RB_CTRL_RST = 16'h0000;
    localparam logic [RB_DW-1:0] RB_CTRL_EXEMPT = 16'hFF00;
    localparam logic [RB_DW-1:0] RB_ZERO = 16'h0000;
    localparam logic [RB_DW-1:0] RB_ONES = 16'hFFFF;

    // Cycles a self-clearing or self-setting bit stays away from its rest value.
    localparam int RB_HOLD_CYCLES = 4;

    // One register access from software: at most one of wr and rd per cycle.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [RB_AW-1:0] addr;
        logic [RB_DW-1:0] wdata;
    } rb_req_t;

    // Read answer, valid for one cycle after the read was taken.
    typedef struct packed {
        logic valid;
        logic [RB_DW-1:0] data;
    } rb_rsp_t;

    // Hardware conditions and set events feeding the status bits.
    typedef struct packed {
        logic [RB_DW-1:0] status;
        logic [RB_DW-1:0] w1c_set;
        logic [RB_DW-1:0] anyclr_set;
        logic [RB_DW-1:0] rdclr_set;
        logic [RB_DW-1:0] latlo_cond;
        logic [RB_DW-1:0] lathi_cond;
        logic [RB_DW-1:0] stk_cond;
    } rb_cond_t;

    // True when the access addresses the given register.
    function automatic logic rb_hit(input rb_req_t r, input logic [RB_AW-1:0] off);
        return r.addr == off;
    endfunction

endpackage
